// File: hdl/decoder_cfg.svh
// constants for the instruction field decoder
`ifndef DECODER_CFG_SVH
`define DECODER_CFG_SVH
`define INSN_W        16
`define REG_NUM_W     4
`define ADDR_W        32
`define OPC_HI        15
`define OPC_LO        12
`define N_HI          11
`define N_LO          8
`define M_HI          7
`define M_LO          4
`define D4_HI         3
`define D4_LO         0
`define D8_HI         7
`define D12_HI        11
`define REG_ZERO      4'h0
`define PC_LONG_MASK  32'hFFFFFFFC
`define NOP_WORD      16'h0009
`define OPF_NONE      4'h0
`define OPF_N         4'h1
`define OPF_M         4'h2
`define OPF_NM        4'h3
`define OPF_MD        4'h4
`define OPF_ND4       4'h5
`define OPF_NMD       4'h6
`define OPF_D         4'h7
`define OPF_D12       4'h8
`define OPF_ND8       4'h9
`define OPF_I         4'hA
`define OPF_NI        4'hB
`define OPF_MAC       4'hC
`endif

// File: hdl/decoder_pkg.sv
// types shared by the instruction field decoder
package decoder_pkg;
  typedef enum logic [3:0] {
    FMT_NONE = 4'h0, FMT_N = 4'h1, FMT_M = 4'h2, FMT_NM = 4'h3,
    FMT_MD = 4'h4, FMT_ND4 = 4'h5, FMT_NMD = 4'h6, FMT_D = 4'h7,
    FMT_D12 = 4'h8, FMT_ND8 = 4'h9, FMT_I = 4'hA, FMT_NI = 4'hB, FMT_MAC = 4'hC
  } format_t;

  typedef enum logic [3:0] {
    AM_NONE = 4'h0, AM_DIRECT = 4'h1, AM_INDIRECT = 4'h2, AM_POSTINC = 4'h3,
    AM_PREDEC = 4'h4, AM_INDEXED = 4'h5, AM_DISP_REG = 4'h6, AM_DISP_GBP = 4'h7,
    AM_INDEXED_GBP = 4'h8, AM_PC_REL = 4'h9, AM_IMMEDIATE = 4'hA, AM_CTRL_SYS = 4'hB,
    AM_ACCUM = 4'hC
  } addr_mode_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2
  } size_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_VALID = 2'b01
  } out_state_t;

  // decode request from the fetch stage
  typedef struct packed {
    logic [15:0] word;
    logic [3:0]  format;
    logic [1:0]  size;
    logic        isStore;
    logic        isBranch;
    logic        isLogicImm;
    logic        isAddrLoad;
    logic        isIndexed;
    logic        isGbpIndexed;
    logic        usesMode;
  } fetch_t;

  // decoded fields for the register file and address generation
  typedef struct packed {
    format_t     format;
    logic        destValid;
    logic [3:0]  destReg;
    addr_mode_t  destMode;
    logic        srcValid;
    logic [3:0]  srcReg;
    addr_mode_t  srcMode;
    logic [31:0] dispScaled;
    logic [31:0] immValue;
    logic        pcMaskLong;
    logic        accumDest;
  } fields_t;
endpackage

// File: hdl/field_extend.sv
// scaling and sign or zero extension of displacement and immediate fields
`include "decoder_cfg.svh"
module field_extend (
  input  wire logic [15:0]          word,
  input  wire decoder_pkg::format_t format,
  input  wire decoder_pkg::size_t   size,
  input  wire logic                 isBranch,
  input  wire logic                 isLogicImm,
  output logic      [31:0]          dispScaled,
  output logic      [31:0]          immValue
);
  function automatic logic [31:0] scaleZero(input logic [11:0] d, input decoder_pkg::size_t s);
    logic [31:0] z;
    z = {20'h00000, d};
    case (s)
      decoder_pkg::SZ_WORD: scaleZero = {z[30:0], 1'b0};
      decoder_pkg::SZ_LONG: scaleZero = {z[29:0], 2'b00};
      default:              scaleZero = z;
    endcase
  endfunction

  always_comb begin
    dispScaled = 32'h00000000;
    case (format)
      decoder_pkg::FMT_MD, decoder_pkg::FMT_ND4, decoder_pkg::FMT_NMD: begin
        dispScaled = scaleZero({8'h00, word[`D4_HI:`D4_LO]}, size);
      end
      decoder_pkg::FMT_D, decoder_pkg::FMT_ND8: begin
        if (isBranch) begin
          dispScaled = {{23{word[`D8_HI]}}, word[`D8_HI:0], 1'b0};
        end else begin
          dispScaled = scaleZero({4'h0, word[`D8_HI:0]}, size);
        end
      end
      decoder_pkg::FMT_D12: begin
        dispScaled = {{19{word[`D12_HI]}}, word[`D12_HI:0], 1'b0};
      end
      default: dispScaled = 32'h00000000;
    endcase
  end

  always_comb begin
    immValue = 32'h00000000;
    if (format == decoder_pkg::FMT_I || format == decoder_pkg::FMT_NI) begin
      if (isLogicImm) begin
        immValue = {24'h000000, word[7:0]};
      end else begin
        immValue = {{24{word[7]}}, word[7:0]};
      end
    end
  end
endmodule

// File: hdl/instr_format_field_decoder.sv
// splits a 16-bit instruction word into register, displacement and immediate fields
// How it works
// - format comes only from the fetch stage's format field, not from the opcode bits
// - n format: bits 11-8 destination, direct or predecrement
// - m format: bits 11-8 source, direct or postincrement
// - nm format: destination 11-8, source 7-4
// - multiply-accumulate: both fields postincrement sources, accumulator result
// - md format: source base 7-4, disp 3-0, dest zero
// - nd4 format: dest base 7-4, disp 3-0, source zero
// - nmd format: disp pairs with store or load base
// - d format: 8-bit displacement, gbp, pc or branch
// - d12 format: 12-bit pc-relative branch offset
// - nd8 format: dest 11-8, pc-relative disp 7-0
// - i format: 8-bit immediate, dest zero, gbp or none
// - ni format: dest 11-8, 8-bit immediate source
// - 4-bit disp zero-extended, scaled by size
// - long pc-relative data masks low pc bits
// - branch disp sign-extended and doubled
// - immediate sign or zero extended by instruction
`include "decoder_cfg.svh"
module instr_format_field_decoder (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 inValid,
  input  wire decoder_pkg::fetch_t  inFetch,
  output logic                      outValid,
  output decoder_pkg::fields_t      outFields
);

  decoder_pkg::fields_t      fieldsNext;
  decoder_pkg::fields_t      fields_reg;
  decoder_pkg::out_state_t   state_reg;
  logic [31:0]               dispScaled;
  logic [31:0]               immValue;
  logic [3:0]                nField;
  logic [3:0]                mField;
  decoder_pkg::format_t      fmt;

  // the fetch stage classifies the opcode; the word itself is the only operand source
  assign fmt    = decoder_pkg::format_t'(inFetch.format);
  assign nField = inFetch.word[`N_HI:`N_LO];
  assign mField = inFetch.word[`M_HI:`M_LO];

  field_extend extendUnit (
    .word       (inFetch.word),
    .format     (fmt),
    .size       (decoder_pkg::size_t'(inFetch.size)),
    .isBranch   (inFetch.isBranch),
    .isLogicImm (inFetch.isLogicImm),
    .dispScaled (dispScaled),
    .immValue   (immValue)
  );

  always_comb begin
    fieldsNext            = '0;
    fieldsNext.format     = fmt;
    fieldsNext.dispScaled = dispScaled;
    fieldsNext.immValue   = immValue;
    case (fmt)
      decoder_pkg::FMT_NONE: begin
        fieldsNext.format = decoder_pkg::FMT_NONE;
      end
      decoder_pkg::FMT_N: begin
        fieldsNext.destValid = 1'b1;
        fieldsNext.destReg   = nField;
        fieldsNext.destMode  = inFetch.usesMode ? decoder_pkg::AM_PREDEC
                                                : decoder_pkg::AM_DIRECT;
        fieldsNext.srcMode   = inFetch.isStore ? decoder_pkg::AM_CTRL_SYS
                                               : decoder_pkg::AM_NONE;
      end
      decoder_pkg::FMT_M: begin
        fieldsNext.srcValid = 1'b1;
        fieldsNext.srcReg   = nField;
        fieldsNext.srcMode  = inFetch.usesMode ? decoder_pkg::AM_POSTINC
                                               : decoder_pkg::AM_DIRECT;
        fieldsNext.destMode = inFetch.isBranch ? decoder_pkg::AM_NONE
                                               : decoder_pkg::AM_CTRL_SYS;
      end
      decoder_pkg::FMT_NM: begin
        fieldsNext.destValid = 1'b1;
        fieldsNext.destReg   = nField;
        fieldsNext.srcValid  = 1'b1;
        fieldsNext.srcReg    = mField;
        fieldsNext.srcMode   = decoder_pkg::AM_DIRECT;
        fieldsNext.destMode  = decoder_pkg::AM_DIRECT;
        if (inFetch.isIndexed) begin
          fieldsNext.destMode = decoder_pkg::AM_INDEXED;
        end else if (inFetch.usesMode && inFetch.isStore) begin
          fieldsNext.destMode = decoder_pkg::AM_PREDEC;
        end else if (inFetch.usesMode) begin
          fieldsNext.srcMode = decoder_pkg::AM_POSTINC;
        end else if (inFetch.isStore) begin
          fieldsNext.destMode = decoder_pkg::AM_INDIRECT;
        end
      end
      decoder_pkg::FMT_MAC: begin
        // both register fields are read pointers; the result lands in the accumulator pair
        fieldsNext.format    = decoder_pkg::FMT_NM;
        fieldsNext.srcValid  = 1'b1;
        fieldsNext.srcReg    = mField;
        fieldsNext.srcMode   = decoder_pkg::AM_POSTINC;
        fieldsNext.destValid = 1'b1;
        fieldsNext.destReg   = nField;
        fieldsNext.destMode  = decoder_pkg::AM_POSTINC;
        fieldsNext.accumDest = 1'b1;
      end
      decoder_pkg::FMT_MD: begin
        fieldsNext.srcValid  = 1'b1;
        fieldsNext.srcReg    = mField;
        fieldsNext.srcMode   = decoder_pkg::AM_DISP_REG;
        fieldsNext.destValid = 1'b1;
        fieldsNext.destReg   = `REG_ZERO;
        fieldsNext.destMode  = decoder_pkg::AM_DIRECT;
      end
      decoder_pkg::FMT_ND4: begin
        fieldsNext.destValid = 1'b1;
        fieldsNext.destReg   = mField;
        fieldsNext.destMode  = decoder_pkg::AM_DISP_REG;
        fieldsNext.srcValid  = 1'b1;
        fieldsNext.srcReg    = `REG_ZERO;
        fieldsNext.srcMode   = decoder_pkg::AM_DIRECT;
      end
      decoder_pkg::FMT_NMD: begin
        fieldsNext.destValid = 1'b1;
        fieldsNext.destReg   = nField;
        fieldsNext.srcValid  = 1'b1;
        fieldsNext.srcReg    = mField;
        fieldsNext.destMode  = inFetch.isStore ? decoder_pkg::AM_DISP_REG
                                               : decoder_pkg::AM_DIRECT;
        fieldsNext.srcMode   = inFetch.isStore ? decoder_pkg::AM_DIRECT
                                               : decoder_pkg::AM_DISP_REG;
      end
      decoder_pkg::FMT_D: begin
        if (inFetch.isBranch) begin
          fieldsNext.srcMode = decoder_pkg::AM_PC_REL;
        end else if (inFetch.isAddrLoad) begin
          fieldsNext.srcMode    = decoder_pkg::AM_PC_REL;
          fieldsNext.destValid  = 1'b1;
          fieldsNext.destReg    = `REG_ZERO;
          fieldsNext.destMode   = decoder_pkg::AM_DIRECT;
          fieldsNext.pcMaskLong = (inFetch.size == 2'(decoder_pkg::SZ_LONG));
        end else if (inFetch.isStore) begin
          fieldsNext.srcValid = 1'b1;
          fieldsNext.srcReg   = `REG_ZERO;
          fieldsNext.srcMode  = decoder_pkg::AM_DIRECT;
          fieldsNext.destMode = decoder_pkg::AM_DISP_GBP;
        end else begin
          fieldsNext.srcMode   = decoder_pkg::AM_DISP_GBP;
          fieldsNext.destValid = 1'b1;
          fieldsNext.destReg   = `REG_ZERO;
          fieldsNext.destMode  = decoder_pkg::AM_DIRECT;
        end
      end
      decoder_pkg::FMT_D12: begin
        fieldsNext.srcMode = decoder_pkg::AM_PC_REL;
      end
      decoder_pkg::FMT_ND8: begin
        fieldsNext.destValid  = 1'b1;
        fieldsNext.destReg    = nField;
        fieldsNext.destMode   = decoder_pkg::AM_DIRECT;
        fieldsNext.srcMode    = decoder_pkg::AM_PC_REL;
        fieldsNext.pcMaskLong = (inFetch.size == 2'(decoder_pkg::SZ_LONG));
      end
      decoder_pkg::FMT_I: begin
        fieldsNext.srcMode = decoder_pkg::AM_IMMEDIATE;
        // a trap has no destination, whatever the gbp flag says
        if (inFetch.isBranch) begin
          fieldsNext.destMode = decoder_pkg::AM_NONE;
        end else if (inFetch.isGbpIndexed) begin
          fieldsNext.destMode = decoder_pkg::AM_INDEXED_GBP;
        end else begin
          fieldsNext.destValid = 1'b1;
          fieldsNext.destReg   = `REG_ZERO;
          fieldsNext.destMode  = decoder_pkg::AM_DIRECT;
        end
      end
      decoder_pkg::FMT_NI: begin
        fieldsNext.destValid = 1'b1;
        fieldsNext.destReg   = nField;
        fieldsNext.destMode  = decoder_pkg::AM_DIRECT;
        fieldsNext.srcMode   = decoder_pkg::AM_IMMEDIATE;
      end
      default: fieldsNext = '0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= decoder_pkg::ST_IDLE;
    end else begin
      state_reg <= inValid ? decoder_pkg::ST_VALID : decoder_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fields_reg <= '0;
    end else if (inValid) begin
      fields_reg <= fieldsNext;
    end
  end

  // bit 0 is set only in the valid state, so the output is a bare flop
  assign outValid  = state_reg[0];
  assign outFields = fields_reg;

  a_out_follows: assert property (@(posedge sys_clk) disable iff (rst)
    inValid |=> outValid) else $error("valid word not presented next cycle");
  a_ni_fields: assert property (@(posedge sys_clk) disable iff (rst)
    inValid && fmt == decoder_pkg::FMT_NI |=> outFields.destReg == $past(inFetch.word[11:8])
    && outFields.immValue[7:0] == $past(inFetch.word[7:0])) else $error("ni fields wrong");
  a_nm_fields: assert property (@(posedge sys_clk) disable iff (rst)
    inValid && fmt == decoder_pkg::FMT_NM |=> outFields.srcReg == $past(inFetch.word[7:4]))
    else $error("nm source wrong");
  a_md_zero: assert property (@(posedge sys_clk) disable iff (rst)
    inValid && fmt == decoder_pkg::FMT_MD |=> outFields.destReg == `REG_ZERO)
    else $error("md dest not zero");
  a_mac_accum: assert property (@(posedge sys_clk) disable iff (rst)
    inValid && fmt == decoder_pkg::FMT_MAC |=> outFields.accumDest
    && outFields.srcMode == decoder_pkg::AM_POSTINC) else $error("mac mode wrong");
  a_d12_branch: assert property (@(posedge sys_clk) disable iff (rst)
    inValid && fmt == decoder_pkg::FMT_D12 |=> outFields.dispScaled[0] == 1'b0
    && outFields.dispScaled[31] == $past(inFetch.word[11])) else $error("d12 disp wrong");
  a_logic_imm: assert property (@(posedge sys_clk) disable iff (rst)
    inValid && fmt == decoder_pkg::FMT_I && inFetch.isLogicImm |=> outFields.immValue[31:8] == 24'h0)
    else $error("logical immediate not zero-extended");
  a_idle_drop: assert property (@(posedge sys_clk) disable iff (rst)
    !inValid |=> !outValid) else $error("valid without a word");
  c_mac: cover property (@(posedge sys_clk) inValid && fmt == decoder_pkg::FMT_MAC);
  c_branch: cover property (@(posedge sys_clk) inValid && fmt == decoder_pkg::FMT_D12);
  c_pcmask: cover property (@(posedge sys_clk) outValid && outFields.pcMaskLong);
endmodule

// File: verification/fetch_model.sv
// fetch stage model that hands one instruction word at a time to the decoder
module fetch_model (
  input  wire logic            sys_clk,
  output logic                 inValid,
  output decoder_pkg::fetch_t  inFetch
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    inValid = 1'b0;
    inFetch = '0;
  end

  // idle cycles scramble the bus so a stale word can never pass for a new one
  task automatic send(input decoder_pkg::fetch_t f, input int gap);
    repeat (gap) begin
      @(posedge sys_clk);
      inValid <= 1'b0;
      inFetch <= ~inFetch;
    end
    @(posedge sys_clk);
    inValid <= 1'b1;
    inFetch <= f;
  endtask

  task automatic idle();
    @(posedge sys_clk);
    inValid <= 1'b0;
    inFetch <= ~inFetch;
  endtask
endmodule

// File: verification/tb.sv
// self-checking bench for the instruction field decoder
`include "decoder_cfg.svh"
`define CHECK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (got), (exp)); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    decoder_pkg::fields_t e;
    decoder_pkg::fields_t m;
  } note_t;

  logic                  sys_clk;
  logic                  rst;
  logic                  inValid;
  decoder_pkg::fetch_t   inFetch;
  logic                  outValid;
  decoder_pkg::fields_t  outFields;
  note_t                 notes[$];
  int                    mismatches;
  int                    samplesChecked;

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
  end
  always #5 sys_clk = ~sys_clk;

  fetch_model u_fetch_model (.sys_clk(sys_clk), .inValid(inValid), .inFetch(inFetch));

  instr_format_field_decoder u_instr_format_field_decoder (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .inValid   (inValid),
    .inFetch   (inFetch),
    .outValid  (outValid),
    .outFields (outFields)
  );

  // only fields the formats pin down are masked in; the rest are designer choices
  function automatic note_t predict(decoder_pkg::fetch_t f);
    note_t n;
    logic [15:0] w;
    logic [3:0] fm;
    logic dv;
    logic sv;
    logic [3:0] dr;
    logic [3:0] sr;
    n = '0;
    w = f.word;
    fm = f.format;
    dv = 1'b0;
    sv = 1'b0;
    dr = w[11:8];
    sr = w[11:8];
    n.e.format = decoder_pkg::format_t'((fm == 4'hC) ? 4'h3 : fm);
    n.m.format = decoder_pkg::format_t'(4'hF);
    n.e.accumDest = (fm == 4'hC);
    n.m.accumDest = 1'b1;
    case (fm)
      4'h0, 4'h8: begin
        n.m.destValid = 1'b1;
        n.m.srcValid = 1'b1;
      end
      4'h1: begin
        dv = 1'b1;
        n.e.destMode = f.usesMode ? decoder_pkg::AM_PREDEC : decoder_pkg::AM_DIRECT;
        n.m.destMode = decoder_pkg::addr_mode_t'(4'hF);
      end
      4'h2: begin
        sv = 1'b1;
        n.e.srcMode = f.usesMode ? decoder_pkg::AM_POSTINC : decoder_pkg::AM_DIRECT;
        n.m.srcMode = decoder_pkg::addr_mode_t'(4'hF);
        n.m.destValid = f.isBranch;
      end
      4'h3, 4'h6: begin
        dv = 1'b1;
        sv = 1'b1;
        sr = w[7:4];
      end
      4'h4: begin
        sv = 1'b1;
        sr = w[7:4];
        dv = 1'b1;
        dr = `REG_ZERO;
      end
      4'h5: begin
        dv = 1'b1;
        dr = w[7:4];
        sv = 1'b1;
        sr = `REG_ZERO;
      end
      4'h9, 4'hB: dv = 1'b1;
      4'hC: begin
        dv = 1'b1;
        sv = 1'b1;
        sr = w[7:4];
        n.e.srcMode = decoder_pkg::AM_POSTINC;
        n.m.srcMode = decoder_pkg::addr_mode_t'(4'hF);
        n.e.destMode = decoder_pkg::AM_POSTINC;
        n.m.destMode = decoder_pkg::addr_mode_t'(4'hF);
      end
      4'hA: begin
        n.m.destValid = f.isBranch;
        if (f.isBranch) n.m.destMode = decoder_pkg::addr_mode_t'(4'hF);
        if (!f.isBranch && f.isGbpIndexed) begin
          n.e.destMode = decoder_pkg::AM_INDEXED_GBP;
          n.m.destMode = decoder_pkg::addr_mode_t'(4'hF);
        end else if (!f.isBranch) begin
          dv = 1'b1;
          dr = `REG_ZERO;
        end
      end
      default: ;
    endcase
    if (dv) begin
      n.e.destValid = 1'b1;
      n.e.destReg = dr;
      n.m.destValid = 1'b1;
      n.m.destReg = 4'hF;
    end
    if (sv) begin
      n.e.srcValid = 1'b1;
      n.e.srcReg = sr;
      n.m.srcValid = 1'b1;
      n.m.srcReg = 4'hF;
    end
    n.m.dispScaled = (fm inside {4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9}) ? 32'hFFFFFFFF : 32'h0;
    if (fm inside {4'h4, 4'h5, 4'h6}) n.e.dispScaled = {28'h0, w[3:0]} << f.size;
    if (fm inside {4'h7, 4'h9}) n.e.dispScaled = {24'h0, w[7:0]} << f.size;
    if (fm == 4'h7 && f.isBranch) n.e.dispScaled = {{24{w[7]}}, w[7:0]} << 1;
    if (fm == 4'h8) n.e.dispScaled = {{20{w[11]}}, w[11:0]} << 1;
    if (fm == 4'hB || (fm == 4'hA && !f.isBranch)) begin
      n.e.immValue = f.isLogicImm ? {24'h0, w[7:0]} : {{24{w[7]}}, w[7:0]};
      n.m.immValue = 32'hFFFFFFFF;
    end
    n.m.pcMaskLong = (fm == 4'h9);
    n.e.pcMaskLong = (fm == 4'h9) && (f.size == 2'h2);
    return n;
  endfunction

  always @(negedge sys_clk) begin : watch
    note_t n;
    decoder_pkg::fields_t g;
    if (!rst && outValid === 1'b1) begin
      if (notes.size() == 0) begin
        `CHECK(outValid, 1'b0)
      end else begin
        n = notes.pop_front();
        g = decoder_pkg::fields_t'(outFields & n.m);
        `CHECK({g.format, g.accumDest}, {n.e.format, n.e.accumDest})
        `CHECK({g.destValid, g.destReg, g.destMode}, {n.e.destValid, n.e.destReg, n.e.destMode})
        `CHECK({g.srcValid, g.srcReg, g.srcMode}, {n.e.srcValid, n.e.srcReg, n.e.srcMode})
        `CHECK(g.dispScaled, n.e.dispScaled)
        `CHECK(g.immValue, n.e.immValue)
        `CHECK(g.pcMaskLong, n.e.pcMaskLong)
      end
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin : main
    decoder_pkg::fetch_t f;
    logic [3:0] fm;
    int wait_n;
    void'($urandom(32'h1DAA));
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHECK({outValid, outFields}, '0)
    @(posedge sys_clk);
    rst <= 1'b0;
    for (int k = 0; k < 390; k++) begin
      fm = 4'(k % 13);
      f = '0;
      f.word = (k < 26) ? ((k < 13) ? 16'h0000 : 16'hFFFF) : 16'($urandom);
      if (fm == 4'h0 && k >= 26 && k < 52) f.word = `NOP_WORD;
      f.format = fm;
      f.size = (fm == 4'h9) ? 2'($urandom_range(2, 1)) : 2'($urandom_range(2, 0));
      f.usesMode = 1'($urandom);
      f.isStore = 1'($urandom);
      f.isLogicImm = 1'($urandom);
      f.isGbpIndexed = 1'($urandom);
      f.isBranch = (fm == 4'h8) || ((fm inside {4'h2, 4'h7, 4'hA}) && 1'($urandom));
      f.isAddrLoad = (fm == 4'h7) && !f.isBranch && 1'($urandom);
      f.isIndexed = (fm == 4'h3) && !f.usesMode && 1'($urandom);
      notes.push_back(predict(f));
      u_fetch_model.send(f, (k < 60) ? 0 : $urandom_range(2, 0));
    end
    u_fetch_model.idle();
    wait_n = 0;
    while (notes.size() != 0 && wait_n < 10) begin
      @(posedge sys_clk);
      wait_n++;
    end
    if (notes.size() != 0) begin
      mismatches++;
      $display("[FAIL] %0t got %0h exp %0h", $time, notes.size(), 0);
    end
    conclude();
  end
endmodule
